// file: core/cbdda_dram_ctrl.sv
// Purpose: Dynamic RAM controller with row/column multiplexing, bank strobes and refresh arbitration.
// Assumes: Requests are levels synchronous to clock; guarded_select low enables them.
// Notes: Refresh drives all four row strobes with the row phase address from a refresh counter.
`default_nettype none
module cbdda_dram_ctrl
	import cbdda_pkg::*;
#(
	parameter int MUX_W = 7
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [MUX_W-1:0] row_addr_in,
	input wire logic [MUX_W-1:0] col_addr_in,
	input wire logic [1:0] bank_sel,
	input wire logic mode_4k,
	input wire logic read_request_n,
	input wire logic write_request_n,
	input wire logic guarded_select,
	input wire logic refresh_request,
	output cbdda_pkg::cbd_dram_t dram,
	output logic sys_cycle_begin,
	output logic xfer_done_strobe
);
	import cbdda_pkg::*;

	typedef enum logic [4:0] {
		CBD_IDLE = 5'h01,
		CBD_ROW = 5'h02,
		CBD_COL = 5'h04,
		CBD_DONE = 5'h08,
		CBD_REFR = 5'h10
	} cbd_dstate_t;

	cbd_dstate_t state;
	cbd_dstate_t next_state;
	logic [CBD_CNT_W-1:0] cnt;
	logic [CBD_CNT_W-1:0] next_cnt;
	logic [MUX_W-1:0] refr_row;
	logic is_write;
	logic defer_ack;
	cbd_dram_t next_dram;

	// Requests only count while guarded_select is low; an access already running is not cut by it.
	wire rd_req = !read_request_n && !guarded_select;
	wire wr_req = !write_request_n && !guarded_select;
	wire any_req = rd_req || wr_req;
	wire cnt_done = (cnt == '0);
	wire [3:0] bank_ras_n = ~(4'h1 << bank_sel);
	// In 4K mode the top column input is a chip select and must stay on the top output in both phases.
	wire [MUX_W-1:0] row_mux = mode_4k ? {col_addr_in[MUX_W-1], row_addr_in[MUX_W-2:0]} : row_addr_in;
	wire [MUX_W-1:0] col_mux = col_addr_in;

	// Access sequencer: row strobe, then column strobe, then the transfer acknowledge.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_dram = dram;
		unique case (state)
			CBD_IDLE: begin
				next_dram.ras_n = CBD_RAS_IDLE;
				next_dram.cas_n = 1'b1;
				next_dram.write_strobe_n = 1'b1;
				// Refresh wins over a simultaneous access; the access then waits its turn.
				if (refresh_request) begin
					next_state = CBD_REFR;
					next_cnt = CBD_CNT_W'(CBD_REFRESH_CYC);
					next_dram.mux_addr = refr_row;
					next_dram.ras_n = 4'h0;
				end else if (any_req) begin
					next_state = CBD_ROW;
					next_cnt = CBD_CNT_W'(CBD_RAS_TO_CAS_CYC);
					next_dram.mux_addr = row_mux;
					next_dram.ras_n = bank_ras_n;
				end
			end
			CBD_ROW: begin
				if (cnt_done) begin
					next_state = CBD_COL;
					next_cnt = CBD_CNT_W'(CBD_CAS_CYC);
					next_dram.mux_addr = col_mux;
					next_dram.cas_n = 1'b0;
					next_dram.write_strobe_n = !is_write;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			CBD_COL: begin
				if (cnt_done) begin
					next_state = CBD_DONE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			CBD_DONE: begin
				next_dram.ras_n = CBD_RAS_IDLE;
				next_dram.cas_n = 1'b1;
				next_dram.write_strobe_n = 1'b1;
				// Wait for the request to go away so one request gives exactly one transfer.
				if (read_request_n && write_request_n) begin
					next_state = CBD_IDLE;
				end
			end
			CBD_REFR: begin
				if (cnt_done) begin
					next_state = CBD_IDLE;
					next_dram.ras_n = CBD_RAS_IDLE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
		endcase
	end

	// State and pin registers.
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= CBD_IDLE;
			cnt <= '0;
			dram <= '{mux_addr: '0, ras_n: CBD_RAS_IDLE, cas_n: 1'b1, write_strobe_n: 1'b1};
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			dram <= next_dram;
		end
	end

	// Access bookkeeping and acknowledges; the begin pulse is held back if the request met a refresh.
	always_ff @(posedge clock) begin
		if (rst) begin
			is_write <= 1'b0;
			defer_ack <= 1'b0;
			refr_row <= '0;
			sys_cycle_begin <= 1'b0;
			xfer_done_strobe <= 1'b0;
		end else begin
			sys_cycle_begin <= 1'b0;
			xfer_done_strobe <= 1'b0;
			if (state == CBD_REFR && cnt_done) begin
				refr_row <= refr_row + 1'b1;
			end
			if (state == CBD_REFR && any_req) begin
				defer_ack <= 1'b1;
			end
			if (state == CBD_IDLE && next_state == CBD_ROW) begin
				is_write <= wr_req;
				sys_cycle_begin <= !defer_ack;
			end
			if (state == CBD_COL && cnt_done) begin
				xfer_done_strobe <= 1'b1;
				sys_cycle_begin <= defer_ack;
				defer_ack <= 1'b0;
			end
		end
	end
endmodule : cbdda_dram_ctrl
`default_nettype wire

// file: core/cbdda_pkg.sv
// Purpose: Shared constants and carrier types for the processor bus decode and DRAM controller.
// Assumes: One processor clock domain at 200 MHz.
// Notes: Cycle codes are {io_or_memory_select, status_bit_one, status_bit_zero}.
`default_nettype none
package cbdda_pkg;
	// Machine cycle status codes.
	localparam logic [2:0] CBD_ST_FETCH = 3'h3;
	localparam logic [2:0] CBD_ST_MEM_READ = 3'h2;
	localparam logic [2:0] CBD_ST_MEM_WRITE = 3'h1;
	localparam logic [2:0] CBD_ST_IO_READ = 3'h6;
	localparam logic [2:0] CBD_ST_IO_WRITE = 3'h5;
	localparam logic [2:0] CBD_ST_INT_ACK = 3'h7;
	localparam logic [2:0] CBD_ST_HALT = 3'h0;
	// Address field positions.
	localparam int CBD_ROM_SEL_LSB = 13;
	localparam int CBD_REG_SEL_W = 7;
	localparam int CBD_DRAM_MUX_W = 7;
	// Reset values.
	localparam logic [7:0] CBD_LOW_ADDR_RST = 8'h00;
	localparam logic [3:0] CBD_RAS_IDLE = 4'hf;
	// DRAM access timing, in clock cycles at 200 MHz (5 ns period).
	localparam int CBD_CLK_PERIOD_NS = 5;
	localparam int CBD_T_RAS_TO_CAS_NS = 10;
	localparam int CBD_T_CAS_NS = 20;
	localparam int CBD_T_REFRESH_NS = 30;
	localparam int CBD_RAS_TO_CAS_CYC = (CBD_T_RAS_TO_CAS_NS + CBD_CLK_PERIOD_NS - 1) / CBD_CLK_PERIOD_NS;
	localparam int CBD_CAS_CYC = (CBD_T_CAS_NS + CBD_CLK_PERIOD_NS - 1) / CBD_CLK_PERIOD_NS;
	localparam int CBD_REFRESH_CYC = (CBD_T_REFRESH_NS + CBD_CLK_PERIOD_NS - 1) / CBD_CLK_PERIOD_NS;
	localparam int CBD_CNT_W = 4;

	// Decoded machine cycle class, one bit per kind.
	typedef struct packed {
		logic fetch;
		logic mem_read;
		logic mem_write;
		logic io_read;
		logic io_write;
		logic int_ack;
		logic bus_idle;
		logic halt;
	} cbd_cycle_t;

	// DRAM pin group driven towards the array.
	typedef struct packed {
		logic [CBD_DRAM_MUX_W-1:0] mux_addr;
		logic [3:0] ras_n;
		logic cas_n;
		logic write_strobe_n;
	} cbd_dram_t;
endpackage : cbdda_pkg
`default_nettype wire

// file: core/cbdda_top.sv
// Purpose: Memory-side bus logic: cycle decode, low address latch, address decode and DRAM control.
// Assumes: All processor signals are synchronous to clock; halt floats are seen as don't care.
// Notes: All outputs are registered; the DRAM controller drives its pins from flip-flops.
//
// Behaviour
// - Low address byte is captured and held; upper byte comes live.
// - Memory cycles: fetch 011, read 010 with read strobe, write 001 with write strobe.
// - I/O read 110, I/O write 101, interrupt acknowledge 111 with its strobe.
// - Bus idle is 010 or 111 with no strobe; halt shows both status low.
// - I/O space of 256 addresses is told apart only by the io select.
// - DRAM row uses low seven address bits, column bits eight to fourteen.
// - Top three address bits decode ROM enables; low thirteen address the ROM.
// - Address bits zero to six select a register and give its load pulse.
// - Seven row inputs feed the row phase; strap selects 4K or 16K mode.
// - Seven column inputs feed column phase; top one is chip select in 4K.
// - Seven mux outputs give row then column; top is chip select in 4K.
// - Write enable to the array is driven during write accesses.
// - Column strobe latches the column address on the mux outputs.
// - Four row strobes; only the selected bank's strobe is asserted for an access, all four for refresh.
// - Each read or write cycle moves exactly one byte.
// - Two bank address inputs choose one of four DRAM banks.
// - Read and write requests count only while guarded select is low.
// - High refresh request asks the arbiter for a refresh cycle.
// - Cycle begin pulses at access start, delayed past refresh to the done strobe.
`default_nettype none
module cbdda_top
	import cbdda_pkg::*;
#(
	parameter int ROW_BITS = 7,
	parameter int REG_COUNT = 128
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr_data_in,
	input wire logic [7:0] addr_high,
	input wire logic addr_latch_enable,
	input wire logic io_or_memory_select,
	input wire logic status_bit_one,
	input wire logic status_bit_zero,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic int_ack_strobe_n,
	input wire logic [1:0] bank_sel,
	input wire logic mode_4k_strap,
	input wire logic guarded_select,
	input wire logic refresh_request,
	output cbdda_pkg::cbd_cycle_t cycle_kind,
	output logic [7:0] low_addr,
	output logic [2:0] rom_enable,
	output logic [12:0] rom_addr,
	output logic io_space,
	output logic [REG_COUNT-1:0] reg_load_pulse,
	output cbdda_pkg::cbd_dram_t dram,
	output logic sys_cycle_begin,
	output logic xfer_done_strobe
);
	import cbdda_pkg::*;

	logic ale_prev;
	logic [7:0] addr_phase;
	logic mode_4k;
	logic strap_taken;
	cbd_cycle_t next_cycle;
	logic [REG_COUNT-1:0] next_load;

	// Status decoded against the strobes; codes 010 and 111 mean a cycle or bus idle, told apart by the strobe.
	wire [2:0] status = {io_or_memory_select, status_bit_one, status_bit_zero};
	wire rd_low = !read_strobe_n;
	wire wr_low = !write_strobe_n;
	wire ia_low = !int_ack_strobe_n;
	wire no_strobe = !rd_low && !wr_low && !ia_low;
	wire ale_fall = ale_prev && !addr_latch_enable;
	wire [15:0] full_addr = {addr_high, low_addr};
	wire mem_access = next_cycle.fetch || next_cycle.mem_read || next_cycle.mem_write;
	wire io_access = next_cycle.io_read || next_cycle.io_write;
	wire reg_write = next_cycle.io_write;

	// One-hot selection decode, used for the ROM enables and the register load pulses.
	function automatic logic [REG_COUNT-1:0] cbd_onehot(input logic [CBD_REG_SEL_W-1:0] idx);
		cbd_onehot = '0;
		cbd_onehot[idx] = 1'b1;
	endfunction : cbd_onehot

	wire [REG_COUNT-1:0] rom_dec = cbd_onehot(CBD_REG_SEL_W'(addr_high[7:5]));

	// Cycle classification from status and strobe levels.
	always_comb begin
		next_cycle = '0;
		next_cycle.fetch = (status == CBD_ST_FETCH) && rd_low;
		next_cycle.mem_read = (status == CBD_ST_MEM_READ) && rd_low;
		next_cycle.mem_write = (status == CBD_ST_MEM_WRITE) && wr_low;
		next_cycle.io_read = (status == CBD_ST_IO_READ) && rd_low;
		next_cycle.io_write = (status == CBD_ST_IO_WRITE) && wr_low;
		next_cycle.int_ack = (status == CBD_ST_INT_ACK) && ia_low && !rd_low && !wr_low;
		next_cycle.bus_idle = no_strobe && (status == CBD_ST_MEM_READ || status == CBD_ST_INT_ACK);
		next_cycle.halt = (status[1:0] == CBD_ST_HALT[1:0]) && !ia_low;
	end

	// A load pulse fires once, on the strobe's falling edge, so one write loads one byte.
	always_comb begin
		next_load = '0;
		if (reg_write && !cycle_kind.io_write) begin
			next_load = cbd_onehot(low_addr[CBD_REG_SEL_W-1:0]);
		end
	end

	// Address latch and strap capture; the strap is sampled once after reset is released.
	// The fall of the latch enable is seen a clock late, when the bus already carries data.
	// So the byte is kept from the last clock the enable stood high and moved over on the fall.
	always_ff @(posedge clock) begin
		if (rst) begin
			ale_prev <= 1'b0;
			addr_phase <= CBD_LOW_ADDR_RST;
			low_addr <= CBD_LOW_ADDR_RST;
			mode_4k <= 1'b0;
			strap_taken <= 1'b0;
		end else begin
			ale_prev <= addr_latch_enable;
			if (addr_latch_enable) begin
				addr_phase <= addr_data_in;
			end
			if (ale_fall) begin
				low_addr <= addr_phase;
			end
			if (!strap_taken) begin
				mode_4k <= mode_4k_strap;
				strap_taken <= 1'b1;
			end
		end
	end

	// Registered decode outputs.
	always_ff @(posedge clock) begin
		if (rst) begin
			cycle_kind <= '0;
			rom_enable <= '0;
			rom_addr <= '0;
			io_space <= 1'b0;
			reg_load_pulse <= '0;
		end else begin
			cycle_kind <= next_cycle;
			rom_enable <= mem_access ? rom_dec[2:0] : 3'h0;
			rom_addr <= full_addr[CBD_ROM_SEL_LSB-1:0];
			io_space <= io_access;
			reg_load_pulse <= next_load;
		end
	end

	// Row phase gets A0..A6 and column phase A8..A14; the request follows memory strobes.
	cbdda_dram_ctrl #(
		.MUX_W(CBD_DRAM_MUX_W)
	) u_dram (
		.clock(clock),
		.rst(rst),
		.row_addr_in(full_addr[ROW_BITS-1:0]),
		.col_addr_in(full_addr[ROW_BITS+7:8]),
		.bank_sel(bank_sel),
		.mode_4k(mode_4k),
		.read_request_n(!(next_cycle.fetch || next_cycle.mem_read)),
		.write_request_n(!next_cycle.mem_write),
		.guarded_select(guarded_select),
		.refresh_request(refresh_request),
		.dram(dram),
		.sys_cycle_begin(sys_cycle_begin),
		.xfer_done_strobe(xfer_done_strobe)
	);
endmodule : cbdda_top
`default_nettype wire

// file: dv/cbdda_checker.sv
// Purpose: Concurrent checks on the ports of the bus decode and DRAM top.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to the top module from the bench file.
`default_nettype none
module cbdda_checker
	import cbdda_pkg::*;
#(
	parameter int REG_COUNT = 128
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic io_or_memory_select,
	input wire logic status_bit_one,
	input wire logic status_bit_zero,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic int_ack_strobe_n,
	input wire logic [1:0] bank_sel,
	input wire cbdda_pkg::cbd_cycle_t cycle_kind,
	input wire logic [7:0] low_addr,
	input wire logic io_space,
	input wire logic [REG_COUNT-1:0] reg_load_pulse,
	input wire cbdda_pkg::cbd_dram_t dram,
	input wire logic sys_cycle_begin,
	input wire logic xfer_done_strobe
);
	import cbdda_pkg::*;
	// Status code packed in the package's bit order.
	wire logic [2:0] st = {io_or_memory_select, status_bit_one, status_bit_zero};
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Decode flags follow their inputs one clock late.
	property p_fetch;
		cycle_kind.fetch == $past(st == CBD_ST_FETCH && !read_strobe_n);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch flag wrong");
	property p_wr;
		cycle_kind.mem_write == $past(st == CBD_ST_MEM_WRITE && !write_strobe_n);
	endproperty
	a_wr: assert property (p_wr) else $error("write flag wrong");
	property p_ia;
		cycle_kind.int_ack == $past(st == CBD_ST_INT_ACK && !int_ack_strobe_n);
	endproperty
	a_ia: assert property (p_ia) else $error("int ack flag wrong");
	property p_io;
		io_space == $past(io_or_memory_select && !(read_strobe_n && write_strobe_n));
	endproperty
	a_io: assert property (p_io) else $error("io space wrong");
	// Only one load pulse, the one the low address names, and only with an I/O write.
	property p_pulse;
		|reg_load_pulse |-> $onehot(reg_load_pulse) && reg_load_pulse[low_addr[6:0]] && cycle_kind.io_write;
	endproperty
	a_pulse: assert property (p_pulse) else $error("load pulse wrong");
	property p_bank;
		$fell(&dram.ras_n) |-> dram.ras_n == 4'h0 || dram.ras_n == ~(4'h1 << $past(bank_sel));
	endproperty
	a_bank: assert property (p_bank) else $error("wrong row strobe");
	// Access walk: begin, column strobe three clocks on, done five after that.
	property p_cas;
		sys_cycle_begin && !xfer_done_strobe |-> ##3 !dram.cas_n ##5 xfer_done_strobe;
	endproperty
	a_cas: assert property (p_cas) else $error("access timing wrong");
	property p_we;
		!dram.write_strobe_n |-> dram.ras_n != 4'hf;
	endproperty
	a_we: assert property (p_we) else $error("write enable outside access");
endmodule : cbdda_checker
`default_nettype wire

// file: dv/cbdda_dram_model.sv
// Purpose: Behavioural DRAM array that latches row, column and bank from the strobes.
// Assumes: Strobes come from flip-flops, so sampling on the clock is safe.
// Notes: Holds no data; the design has no data path to the array.
`default_nettype none
module cbdda_dram_model
	import cbdda_pkg::*;
(
	input wire logic clock,
	input wire cbdda_pkg::cbd_dram_t dram,
	output logic [6:0] row,
	output logic [6:0] col,
	output logic [3:0] ras
);
	import cbdda_pkg::*;
	logic [3:0] ras_q = 4'hf;
	logic cas_q = 1'b1;
	// Latch on falling strobes, a clock late, while the mux still holds that phase.
	always_ff @(posedge clock) begin
		ras_q <= dram.ras_n;
		cas_q <= dram.cas_n;
		if (&ras_q && !(&dram.ras_n)) begin
			row <= dram.mux_addr;
			ras <= dram.ras_n;
		end
		if (cas_q && !dram.cas_n) begin
			col <= dram.mux_addr;
		end
	end
endmodule : cbdda_dram_model
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the bus decode and DRAM controller top.
// Assumes: 16K mode strap until the last scenario resets with it high for 4K; one 200 MHz clock.
// Notes: Decode runs with guarded_select high so no DRAM access starts.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cbdda_pkg::*;
	logic clock = 0, rst = 1, ale = 0, io = 0, s1 = 0, s0 = 0, rd_n = 1, wr_n = 1, ia_n = 1;
	logic strap = 0, gs = 1, rq = 0, ios, sb, xd;
	logic [7:0] ad = 8'h00, ah = 8'h00, la;
	logic [1:0] bs = 2'h0;
	logic [2:0] re;
	logic [12:0] ra;
	logic [127:0] rlp;
	logic [6:0] row, col;
	logic [3:0] ras;
	cbd_cycle_t ck;
	cbd_dram_t dram;
	int failures = 0, checks = 0;
	// Entries: status code, strobes {read, write, int ack}, expected flags.
	logic [13:0] tbl [9] = '{14'h1b80, 14'h1340, 14'h0d20, 14'h3310, 14'h2d08, 14'h3e04, 14'h1702, 14'h3f02,
		14'h0701};
	always #2.5 clock = ~clock;
	cbdda_top DUT (.clock(clock), .rst(rst), .addr_data_in(ad), .addr_high(ah), .addr_latch_enable(ale),
		.io_or_memory_select(io), .status_bit_one(s1), .status_bit_zero(s0), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .int_ack_strobe_n(ia_n), .bank_sel(bs), .mode_4k_strap(strap),
		.guarded_select(gs), .refresh_request(rq), .cycle_kind(ck), .low_addr(la), .rom_enable(re),
		.rom_addr(ra), .io_space(ios), .reg_load_pulse(rlp), .dram(dram), .sys_cycle_begin(sb),
		.xfer_done_strobe(xd));
	cbdda_dram_model p (.clock(clock), .dram(dram), .row(row), .col(col), .ras(ras));
	task automatic cmp(string n, logic [127:0] e, logic [127:0] s);
		checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", n, e, s);
		end
	endtask : cmp
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Status and address first, strobe two clocks after the latch enable falls.
	task automatic cyc(logic [2:0] st, logic [15:0] a, logic [2:0] strb);
		@(posedge clock);
		ale <= 1'b1;
		ad <= a[7:0];
		ah <= a[15:8];
		{io, s1, s0} <= st;
		@(posedge clock);
		ale <= 1'b0;
		ad <= ~a[7:0];
		repeat (2) @(posedge clock);
		{rd_n, wr_n, ia_n} <= strb;
		@(posedge clock);
		#1;
	endtask : cyc
	task automatic idle;
		@(posedge clock);
		{rd_n, wr_n, ia_n} <= 3'h7;
		repeat (3) @(posedge clock);
	endtask : idle
	task automatic t_reset;
		#1;
		cmp("dram idle", 13'h3f, dram);
	endtask : t_reset
	task automatic t_decode;
		logic [15:0] a;
		for (int i = 0; i < 9; i++) begin
			a = 16'(i * 16'h2011 + 16'h00a5);
			cyc(tbl[i][13:11], a, tbl[i][10:8]);
			cmp("cycle_kind", tbl[i][7:0], ck);
			cmp("io_space", |tbl[i][4:3], ios);
			cmp("low_addr", a[7:0], la);
			if (tbl[i][3]) cmp("pulse", 128'h1 << a[6:0], rlp);
			if (|tbl[i][7:6]) cmp("rom_en", 3'(8'h1 << a[15:13]), re);
			if (|tbl[i][7:6]) cmp("rom_addr", a[12:0], ra);
			idle();
		end
	endtask : t_decode
	// One access: column strobe four clocks after the request, then wait for done.
	task automatic mem(logic [2:0] st, logic [15:0] a, logic [2:0] strb, logic we);
		int i;
		cyc(st, a, strb);
		cmp("begin", 1'b1, sb);
		repeat (4) @(posedge clock);
		#1;
		cmp("cas_n", 1'b0, dram.cas_n);
		cmp("we_n", we, dram.write_strobe_n);
		for (i = 0; i < 40 && xd !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		if (i == 40) begin
			failures++;
			final_report();
		end else begin
			cmp("row", strap ? {a[14], a[5:0]} : a[6:0], row);
			cmp("col", a[14:8], col);
			cmp("bank", 4'(~(4'h1 << bs)), ras);
		end
		idle();
	endtask : mem
	task automatic t_dram;
		gs <= 1'b0;
		for (int b = 0; b < 4; b++) begin
			bs <= 2'(b);
			mem(CBD_ST_MEM_READ, 16'(16'h1234 + b * 16'h1111), 3'b011, 1'b1);
		end
		mem(CBD_ST_FETCH, 16'h5a5a, 3'b011, 1'b1);
		mem(CBD_ST_MEM_WRITE, 16'h7e81, 3'b101, 1'b0);
	endtask : t_dram
	task automatic t_guard;
		gs <= 1'b1;
		cyc(CBD_ST_MEM_READ, 16'h0102, 3'b011);
		repeat (10) @(posedge clock);
		#1;
		cmp("guarded ras", 4'hf, dram.ras_n);
		idle();
	endtask : t_guard
	task automatic t_refresh;
		@(posedge clock);
		rq <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		cmp("refresh ras", 4'h0, dram.ras_n);
		@(posedge clock);
		rq <= 1'b0;
		repeat (10) @(posedge clock);
	endtask : t_refresh
	// An access asked for during a refresh: its begin pulse must wait for the done strobe.
	task automatic t_defer;
		int i;
		int early = 0;
		@(posedge clock);
		gs <= 1'b0;
		rq <= 1'b1;
		cyc(CBD_ST_MEM_READ, 16'h2468, 3'b011);
		@(posedge clock);
		rq <= 1'b0;
		#1;
		for (i = 0; i < 40 && xd !== 1'b1; i++) begin
			if (sb === 1'b1) early++;
			@(posedge clock);
			#1;
		end
		if (i == 40) begin
			failures++;
			final_report();
		end else begin
			cmp("early begin", 0, early);
			cmp("late begin", 1'b1, sb);
		end
		idle();
	endtask : t_defer
	// A second reset with the strap high; the top mux line then carries the chip select in the row phase.
	task automatic t_4k;
		@(posedge clock);
		strap <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		cmp("dram idle 4k", 13'h3f, dram);
		mem(CBD_ST_MEM_READ, 16'hc3a5, 3'b011, 1'b1);
	endtask : t_4k
	// Reset for twenty clocks, then the scenarios in turn.
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		t_reset();
		t_decode();
		t_dram();
		t_guard();
		t_refresh();
		t_defer();
		t_4k();
		final_report();
	end
endmodule : tb
bind cbdda_top cbdda_checker #(.REG_COUNT(REG_COUNT)) u_chk (.clock(clock), .rst(rst),
	.io_or_memory_select(io_or_memory_select), .status_bit_one(status_bit_one),
	.status_bit_zero(status_bit_zero), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.int_ack_strobe_n(int_ack_strobe_n), .bank_sel(bank_sel), .cycle_kind(cycle_kind), .low_addr(low_addr),
	.io_space(io_space), .reg_load_pulse(reg_load_pulse), .dram(dram), .sys_cycle_begin(sys_cycle_begin),
	.xfer_done_strobe(xfer_done_strobe));
`default_nettype wire
